// file: src/sor_word_recovery.sv
// What this block does
// R1: Far transmitter sends the serial stream at nominal 270 Mb/s.
// R2: Recovered bits are aligned to the word boundary before hand-off.
// R3: One clock synth unit gives the receive clock and its inverse.
// R4: That single clock synth unit serves every receiver channel.
// R5: Sampling point is monitored continuously for needed adjustment.
// R6: Many samples per period; edges located; sample point kept away.
// R7: Two delay chains of eight stages, eight copies each.
// R8: Each chain captures alternate bits, at half line rate.
// R9: One chain on positive phase, other on inverted phase.
// R10: Inverted-phase samples move to positive phase before use.
// R11: Edges come from XOR of neighbouring sample pairs.
// R12: A state machine reads edges and decides on moving the point.
// R13: Two bits per cycle normally; three when the line runs fast.
// R14: One bit in a cycle when the line runs slow.
// R15: The comma symbol marks the word boundary.
// R16: Mode 0 locks on first comma; mode 1 needs two in five words.
// R17: One to three bits per cycle pack into 10-bit words with strobe.
// R18: Sampling point moves at most one position per decision.
`timescale 1ns/1ps
`include "sor_consts.svh"

module sor_word_recovery
   import sor_pkg::*;
(
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic [7:0] TAP_IN,
   input wire logic SYNC_MODE,
   output logic [9:0] WORD_OUT,
   output logic WORD_VALID,
   output logic LOCKED,
   output logic [2:0] SAMPLE_POS
);

   // R3: clock synth unit
   // R4: shared by channels; a multi-channel top would hoist these two nets
   logic sample_clk_pos_phase;
   logic sample_clk_neg_phase;
   assign sample_clk_pos_phase = MCLK;
   assign sample_clk_neg_phase = ~MCLK;

   logic [7:0] pos_q, pos_d, neg_q, neg_d, negx_q, negx_d;
   // R7: eight-stage capture
   // R8: alternate bits per chain
   always_comb begin
      pos_d = TAP_IN;
      neg_d = TAP_IN;
      // R10: cross to positive phase
      negx_d = neg_q;
   end
   // R9: positive phase chain
   always_ff @(posedge sample_clk_pos_phase) begin
      pos_q <= SYS_RST ? 8'h00 : pos_d;
      negx_q <= SYS_RST ? 8'h00 : negx_d;
   end
   // R9: inverted phase chain
   always_ff @(posedge sample_clk_neg_phase) begin
      neg_q <= SYS_RST ? 8'h00 : neg_d;
   end

   // R11: neighbour XOR edges
   logic [6:0] edges;
   assign edges = (pos_q[6:0] ^ pos_q[7:1]) | (negx_q[6:0] ^ negx_q[7:1]);

   logic [2:0] idx_q, idx_d;
   sor_pick_type pick_q, pick_d;
   logic edge_l, edge_r;
   // R5: decision every cycle
   // R12: point adjust machine
   always_comb begin
      idx_d = idx_q;
      pick_d = ST_TWO;
      edge_l = (idx_q != 3'h0) && edges[idx_q - 3'h1];
      edge_r = (idx_q != 3'h7) && edges[idx_q];
      // R6: step away from edges
      // R18: single position step
      if (edge_r && !edge_l) begin
         idx_d = idx_q - 3'h1;
         // R13: wrap earlier, take three
         if (idx_q == 3'h0) begin
            pick_d = ST_THREE;
         end
      end else if (edge_l && !edge_r) begin
         idx_d = idx_q + 3'h1;
         // R14: wrap later, take one
         if (idx_q == 3'h7) begin
            pick_d = ST_ONE;
         end
      end
   end
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         idx_q <= `SOR_IDX_RST;
         pick_q <= ST_TWO;
      end else begin
         idx_q <= idx_d;
         pick_q <= pick_d;
      end
   end

   // Bit extraction and word packing
   logic [23:0] sr_q, sr_d;
   logic [3:0] cnt_q, cnt_d;
   logic [1:0] nb;
   logic [3:0] tot;
   logic [3:0] ex;
   logic [9:0] win;
   logic comma_hit;
   logic [3:0] comma_k;
   sor_lock_type lock_q, lock_d;
   logic [2:0] wcnt_q, wcnt_d;
   logic [9:0] word_q, word_d;
   logic wval_q, wval_d;
   logic locked_q, locked_d;

   always_comb begin
      sr_d = sr_q;
      nb = 2'h2;
      // Inverted-phase copy is the older bit of each pair, so it goes first
      // R13: normal two, occasional three
      // R14: occasional one
      unique case (pick_q)
         ST_TWO: sr_d = {sr_q[21:0], negx_q[idx_q], pos_q[idx_q]};
         ST_ONE: begin
            nb = 2'h1;
            sr_d = {sr_q[22:0], pos_q[idx_q]};
         end
         ST_THREE: begin
            nb = 2'h3;
            // Least delayed tap already shows the next bit
            sr_d = {sr_q[20:0], negx_q[idx_q], pos_q[idx_q], pos_q[0]};
         end
         default: sr_d = {sr_q[21:0], negx_q[idx_q], pos_q[idx_q]};
      endcase
      // R15: comma search on new windows
      comma_hit = 1'b0;
      comma_k = 4'h0;
      for (int k = 0; k < 3; k++) begin
         win = sr_d[k +: 10];
         if ((k < int'(nb)) && !comma_hit &&
             (win == `SOR_COMMA_NEG || win == `SOR_COMMA_POS)) begin
            comma_hit = 1'b1;
            comma_k = 4'(k);
         end
      end
      // R17: accumulate into words
      tot = cnt_q + 4'(nb);
      ex = tot - 4'ha;
      cnt_d = tot;
      word_d = word_q;
      wval_d = 1'b0;
      lock_d = lock_q;
      wcnt_d = wcnt_q;
      if (tot >= 4'ha) begin
         cnt_d = ex;
         word_d = sr_d[ex +: 10];
         wval_d = (lock_q == LK_LOCKED);
         if (lock_q == LK_CAND) begin
            wcnt_d = wcnt_q + 3'h1;
         end
      end
      // R16: framing qualifier
      // R2: realign while hunting
      unique case (lock_q)
         LK_HUNT: if (comma_hit) begin
            cnt_d = comma_k;
            word_d = sr_d[comma_k +: 10];
            wcnt_d = 3'h0;
            lock_d = SYNC_MODE ? LK_CAND : LK_LOCKED;
            wval_d = !SYNC_MODE;
         end
         LK_CAND: if (tot >= 4'ha && (word_d == `SOR_COMMA_NEG ||
                                      word_d == `SOR_COMMA_POS)) begin
            lock_d = LK_LOCKED;
            wval_d = 1'b1;
         end else if (wcnt_d >= `SOR_SYNC_WINDOW) begin
            lock_d = LK_HUNT;
         end
         LK_LOCKED: lock_d = LK_LOCKED;
         default: lock_d = LK_HUNT;
      endcase
      // Registered copy keeps the pin off the state decode
      locked_d = (lock_d == LK_LOCKED);
   end
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         sr_q <= 24'h00_0000;
         cnt_q <= `SOR_CNT_RST;
         lock_q <= LK_HUNT;
         wcnt_q <= 3'h0;
         word_q <= 10'h000;
         wval_q <= 1'b0;
         locked_q <= 1'b0;
      end else begin
         sr_q <= sr_d;
         cnt_q <= cnt_d;
         lock_q <= lock_d;
         wcnt_q <= wcnt_d;
         word_q <= word_d;
         wval_q <= wval_d;
         locked_q <= locked_d;
      end
   end

   // Outputs straight from flip-flops
   assign WORD_OUT = word_q;
   assign WORD_VALID = wval_q;
   assign LOCKED = locked_q;
   assign SAMPLE_POS = idx_q;

   step_one_a: assert property ( // R18
      @(posedge MCLK) disable iff (SYS_RST)
      ##1 ((idx_q - $past(idx_q)) inside {3'h0, 3'h1, 3'h7}))
      else $error("Sampling point jumped by more than one");
   pick_three_a: assert property ( // R13
      @(posedge MCLK) disable iff (SYS_RST)
      (pick_q == ST_THREE) |-> (idx_q == 3'h7 && $past(idx_q) == 3'h0))
      else $error("Three-bit pick without earlier wrap");
   pick_one_a: assert property ( // R14
      @(posedge MCLK) disable iff (SYS_RST)
      (pick_q == ST_ONE) |-> (idx_q == 3'h0 && $past(idx_q) == 3'h7))
      else $error("One-bit pick without later wrap");
   edge_move_a: assert property ( // R12
      @(posedge MCLK) disable iff (SYS_RST)
      (edge_r && !edge_l) |=> (idx_q == $past(idx_q) - 3'h1))
      else $error("Point did not retreat from edge");
   neg_xfer_a: assert property ( // R10
      @(posedge MCLK) disable iff (SYS_RST)
      ##1 (negx_q == $past(neg_q)))
      else $error("Inverted-phase samples not transferred");
   word_gap_a: assert property ( // R17
      @(posedge MCLK) disable iff (SYS_RST)
      (WORD_VALID && $past(LOCKED)) |=> !WORD_VALID [*2])
      else $error("Words closer than ten bits allow");
   mode_zero_a: assert property ( // R16
      @(posedge MCLK) disable iff (SYS_RST)
      (lock_q == LK_HUNT && comma_hit && !SYNC_MODE) |=>
      (LOCKED && WORD_VALID))
      else $error("Mode 0 did not lock on first comma");
   mode_one_a: assert property ( // R16
      @(posedge MCLK) disable iff (SYS_RST)
      (lock_q == LK_HUNT && comma_hit && SYNC_MODE) |=>
      (lock_q == LK_CAND && !WORD_VALID))
      else $error("Mode 1 locked on a single comma");
   cand_window_a: assert property ( // R16
      @(posedge MCLK) disable iff (SYS_RST)
      (lock_q == LK_CAND) |-> (wcnt_q < `SOR_SYNC_WINDOW))
      else $error("Candidate held past five words");
   valid_locked_a: assert property ( // R2
      @(posedge MCLK) disable iff (SYS_RST)
      WORD_VALID |-> LOCKED)
      else $error("Word handed on before alignment");

endmodule : sor_word_recovery

// file: common/sor_consts.svh
`ifndef SOR_CONSTS_SVH
`define SOR_CONSTS_SVH

// Delay chain and word geometry
`define SOR_TAPS 8
`define SOR_WORD_BITS 10
`define SOR_SHIFT_BITS 24
// Comma symbol, both running disparities, first bit in time at MSB
`define SOR_COMMA_NEG 10'h0fa
`define SOR_COMMA_POS 10'h305
// Confirmation window for the two-comma framing mode, in words
`define SOR_SYNC_WINDOW 3'h5
// Reset values
`define SOR_IDX_RST 3'h3
`define SOR_CNT_RST 4'h0

`endif

// file: common/sor_pkg.sv
package sor_pkg;

   typedef enum logic [1:0] {
      ST_TWO = 2'b00,
      ST_ONE = 2'b01,
      ST_THREE = 2'b10
   } sor_pick_type;

   typedef enum logic [1:0] {
      LK_HUNT = 2'b00,
      LK_CAND = 2'b01,
      LK_LOCKED = 2'b10
   } sor_lock_type;

endpackage : sor_pkg

// file: sim/sor_line_model.sv
`timescale 1ns/1ps
module sor_line_model (
   input wire logic clk,
   input wire logic [3:0] skew,
   output logic [7:0] tap_out
);
   logic bits_pend[$];
   logic cur = 1'b0;

   task automatic send_word(input logic [9:0] w);
      for (int i = 9; i >= 0; i--) begin
         bits_pend.push_back(w[i]);
      end
   endtask : send_word

   // Late taps still show the old bit when skew is set
   task automatic put;
      logic nb;
      nb = (bits_pend.size() == 0) ? 1'b0 : bits_pend.pop_front();
      for (int k = 0; k < 8; k++) begin
         tap_out[k] = (k + skew >= 8) ? cur : nb;
      end
      cur = nb;
   endtask : put

   initial tap_out = 8'h00;

   always begin
      @(posedge clk);
      #2 put();
      @(negedge clk);
      #2 put();
   end
endmodule : sor_line_model

// file: sim/test_sor_word_recovery.sv
`timescale 1ns/1ps
module test_sor_word_recovery;
   import sor_pkg::*;
   logic MCLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic SYNC_MODE = 1'b0;
   logic [3:0] skew = 4'h0;
   logic [7:0] TAP_IN;
   logic [9:0] WORD_OUT;
   logic WORD_VALID;
   logic LOCKED;
   logic [2:0] SAMPLE_POS;
   logic [2:0] prev_pos = 3'h3;
   logic [9:0] exp_q[$];
   logic watch = 1'b0;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   int moves = 0;
   integer seed = 32'h8a40_6e29;

   always #12.5 MCLK = ~MCLK;

   sor_word_recovery u_sor_word_recovery (.MCLK(MCLK), .SYS_RST(SYS_RST),
      .TAP_IN(TAP_IN), .SYNC_MODE(SYNC_MODE), .WORD_OUT(WORD_OUT),
      .WORD_VALID(WORD_VALID), .LOCKED(LOCKED), .SAMPLE_POS(SAMPLE_POS));
   sor_line_model u_sor_line_model (.clk(MCLK), .skew(skew),
      .tap_out(TAP_IN));

   task automatic check(input string nm, input logic [9:0] seen,
         input logic [9:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done

   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         test_done();
      end
   end

   // Word stream and sampling point watcher
   always @(posedge MCLK) begin
      #1;
      if (WORD_VALID === 1'b1 && watch) begin
         check("lock", {9'h000, LOCKED}, 10'h001);
         if (exp_q.size() == 0) check("count", 10'h001, 10'h000);
         else check("word", WORD_OUT, exp_q.pop_front());
      end
      if (SYS_RST === 1'b0 && SAMPLE_POS !== prev_pos) begin
         moves++;
         check("step", {9'h000, ((SAMPLE_POS - prev_pos) inside
            {3'h1, 3'h7})}, 10'h001);
      end
      prev_pos = SAMPLE_POS;
   end

   task automatic send(input logic [9:0] w, input logic keep);
      u_sor_line_model.send_word(w);
      if (keep) exp_q.push_back(w);
   endtask : send

   task automatic rand_words(input int n);
      for (int i = 0; i < n; i++) send(10'($random(seed)), 1'b1);
   endtask : rand_words

   task automatic drain;
      int t;
      t = 0;
      while (u_sor_line_model.bits_pend.size() != 0 && t < 2000) begin
         @(posedge MCLK);
         t++;
      end
      repeat (5) @(posedge MCLK);
      #3;
      check("pending", 10'(exp_q.size()), 10'h000);
      watch = 1'b0;
   endtask : drain

   task automatic do_reset(input logic mode);
      @(posedge MCLK);
      #2;
      SYS_RST = 1'b1;
      SYNC_MODE = mode;
      skew = 4'h0;
      watch = 1'b0;
      exp_q.delete();
      u_sor_line_model.bits_pend.delete();
      repeat (12) @(posedge MCLK);
      #3;
      check("pos rst", {7'h00, SAMPLE_POS}, 10'h003);
      check("lock rst", {9'h000, LOCKED}, 10'h000);
      check("word rst", WORD_OUT, 10'h000);
      @(posedge MCLK);
      #2 SYS_RST = 1'b0;
   endtask : do_reset

   initial begin
      do_reset(1'b0);
      watch = 1'b1;
      repeat (3) send(10'h000, 1'b0);
      send(10'h0fa, 1'b1);
      rand_words(8);
      drain();
      check("lock m0", {9'h000, LOCKED}, 10'h001);
      $display("test mode0 done");
      do_reset(1'b1);
      watch = 1'b1;
      send(10'h305, 1'b0);
      repeat (8) send(10'h000, 1'b0);
      drain();
      check("lone comma", {9'h000, LOCKED}, 10'h000);
      watch = 1'b1;
      send(10'h305, 1'b0);
      send(10'h000, 1'b0);
      send(10'h0fa, 1'b1);
      rand_words(6);
      drain();
      check("lock m1", {9'h000, LOCKED}, 10'h001);
      $display("test mode1 done");
      do_reset(1'b0);
      // Edge walked across the taps to force both wraps; words not compared
      rand_words(40);
      for (int s = 5; s >= 0; s--) begin
         repeat (20) @(posedge MCLK);
         #2 skew = (s == 0) ? 4'h7 : 4'(s);
      end
      repeat (20) @(posedge MCLK);
      exp_q.delete();
      #3;
      check("moved", 10'(moves > 0), 10'h001);
      check("wrap pos", {7'h00, SAMPLE_POS}, 10'h007);
      $display("test sample point done");
      test_done();
   end
endmodule : test_sor_word_recovery
